// >>> common/fpa_pkg.sv
// Shared types and constants of the floating add/subtract align sequencer
`default_nettype none

package fpa_pkg;

    // ------------------------------------------------------------------
    // Mantissa layout: bit 57 is the extension bit, bit 56 the sign,
    // bits 55..32 the upper digits, bits 31..0 the lower word
    // ------------------------------------------------------------------
    localparam int MANT_W        = 58;
    localparam int HI_W          = 26;
    localparam int LO_W          = 32;
    localparam int EXT_BIT       = 57;
    localparam int SIGN_BIT      = 56;
    localparam int HEX_SHIFT     = 4;
    localparam int GUARD_ZERO_LO = 24;   // Short format zero digit, lower bit
    localparam int GUARD_ZERO_HI = 27;   // Short format zero digit, upper bit
    localparam int EXP_TOP_LO    = 24;   // Exponent byte inside the lower word
    localparam int EXP_TOP_HI    = 31;

    localparam logic [7:0] EXP_BIAS = 8'h40;

    // ------------------------------------------------------------------
    // Operation codes (low seven bits; the top bit only marks indirection)
    // ------------------------------------------------------------------
    localparam logic [6:0] OP_ADD_SHORT = 7'h3d;
    localparam logic [6:0] OP_SUB_SHORT = 7'h3c;
    localparam logic [6:0] OP_ADD_LONG  = 7'h1d;
    localparam logic [6:0] OP_SUB_LONG  = 7'h1c;
    localparam int         OP_ADD_BIT   = 0;
    localparam int         OP_SHORT_BIT = 5;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_ACC_HI  = 8'h04;
    localparam logic [7:0] REG_ACC_LO  = 8'h08;
    localparam logic [7:0] REG_OPND_HI = 8'h0c;
    localparam logic [7:0] REG_OPND_LO = 8'h10;
    localparam logic [7:0] REG_EXP     = 8'h14;

    localparam int CTRL_START_BIT   = 8;
    localparam int STAT_BUSY_BIT    = 8;
    localparam int STAT_DONE_BIT    = 9;
    localparam int STAT_ILLEGAL_BIT = 10;
    localparam int STAT_SW1_BIT     = 11;
    localparam int STAT_MOVE_BIT    = 12;
    localparam int STAT_FPR_BIT     = 13;
    localparam int STAT_RTZ_BIT     = 14;
    localparam int STAT_AUG_BIT     = 15;
    localparam int STAT_ADD_BIT     = 16;
    localparam int STAT_PHASE_LO    = 17;
    localparam int EXP_SAVED_LO     = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [MANT_W-1:0] fpa_mant_t;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_DECIDE,
        PH_ALIGN,
        PH_ADD,
        PH_POST
    } fpa_phase_t;

    typedef enum logic [2:0] {
        AD_PASS_ACC,
        AD_NEG_ACC,
        AD_PASS_OPND,
        AD_NEG_OPND,
        AD_SUM,
        AD_DIFF
    } fpa_adder_t;

    typedef struct packed {
        logic       align_augend_right;
        logic       align_addend_right;
        logic       operand_sign_reversed;
        logic       move_augend_request;
        logic       polarity_reversed_flag;
        logic       result_zero_flag;
        logic       done;
        logic       illegal;
    } fpa_flags_t;

    typedef struct packed {
        fpa_phase_t  phase;
        fpa_adder_t  mode;
        fpa_mant_t   acc;
        fpa_mant_t   opnd;
        logic [7:0]  exp_diff;
        logic [7:0]  saved_exp;
        logic [7:0]  opcode;
        logic        first_clk;
        fpa_flags_t  flags;
        logic [31:0] rdata;
    } fpa_state_t;

    localparam fpa_state_t FPA_STATE_RST = '0;

endpackage : fpa_pkg

`default_nettype wire

// >>> verilog/fpa_align_seq.sv
// Floating add/subtract sequencer: exponent compare, hex alignment, mantissa add
//
// Design decisions made here: the register addresses and the plain strobed port.
`default_nettype none

module fpa_align_seq
    import fpa_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              CLK,
    input  wire logic              RSTN,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [31:0]       WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [31:0]       RDATA,
    input  wire logic              SHORT_TIMING_CLASS,
    input  wire logic              FIRST_PHASE,
    input  wire logic              NINTH_PHASE,
    output logic                   BUSY,
    output logic                   DONE
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_addr_check
        $error("fpa_align_seq: ADDR_W must lie between 5 and 8");
    end

    // ------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------
    fpa_state_t st_reg;
    fpa_state_t st_next;

    logic [7:0] bus_addr;
    logic       op_add;
    logic       op_short;
    logic       op_legal;
    logic       exp_zero;
    logic       exp_neg;
    logic       addsub_prepare;
    logic       sum_zero;
    fpa_mant_t  sum_bus;
    fpa_mant_t  shifted;
    fpa_mant_t  adder_src_opnd;
    logic [7:0] exp_minus_bias;

    // Address zero-extended so the compares use full-width constants
    assign bus_addr = 8'(ADDR);

    // Adder: the preset mode picked on the previous clock decides the function
    function automatic fpa_mant_t adder_out(input fpa_adder_t m, input fpa_mant_t a,
                                            input fpa_mant_t d);
        fpa_mant_t r;
        r = '0;
        case (m)
            AD_PASS_ACC:  r = a;
            AD_NEG_ACC:   r = -a;
            AD_PASS_OPND: r = d;
            AD_NEG_OPND:  r = -d;
            AD_SUM:       r = a + d;
            AD_DIFF:      r = a - d;
            default:      r = '0;
        endcase
        return r;
    endfunction : adder_out

    // Hex right shift of a magnitude, with the short-format guard treatment
    function automatic fpa_mant_t hex_right(input fpa_mant_t s, input logic short_fmt);
        fpa_mant_t r;
        r = s >> HEX_SHIFT;
        if (short_fmt) begin
            r[GUARD_ZERO_HI:GUARD_ZERO_LO] = '0;
        end
        return r;
    endfunction : hex_right

    // ------------------------------------------------------------------
    // Operation decode and exponent tests
    // ------------------------------------------------------------------
    // Only the low seven bits matter; the top bit marks an indirect form
    assign op_legal = (st_reg.opcode[6:0] == OP_ADD_SHORT) ||
                      (st_reg.opcode[6:0] == OP_SUB_SHORT) ||
                      (st_reg.opcode[6:0] == OP_ADD_LONG)  ||
                      (st_reg.opcode[6:0] == OP_SUB_LONG);
    assign op_add   = st_reg.opcode[OP_ADD_BIT];
    assign op_short = st_reg.opcode[OP_SHORT_BIT];
    assign exp_zero = (st_reg.exp_diff == 8'h00);
    assign exp_neg  = st_reg.exp_diff[7];

    // Alignment ends when both nibbles are zero or the mantissa vanished
    assign addsub_prepare = (st_reg.phase == PH_ALIGN) &&
                            (exp_zero || st_reg.flags.result_zero_flag);

    // On the first clock of the positive case the addend still sits in the
    // operand register; it is the value that gets shifted, so feed it here
    assign adder_src_opnd = st_reg.opnd;
    assign sum_bus  = adder_out(st_reg.mode, st_reg.acc, adder_src_opnd);
    assign sum_zero = (sum_bus[EXT_BIT-1:0] == '0);
    assign shifted  = hex_right(sum_bus, op_short);

    // Sign bit set means the saved exponent is held inverted
    assign exp_minus_bias = (st_reg.saved_exp[7] ? ~st_reg.saved_exp : st_reg.saved_exp)
                            - EXP_BIAS;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rdata = '0;

        // Register read: data stand in the cycle after the strobe only
        if (RD) begin
            case (bus_addr)
                REG_CTRL: begin
                    st_next.rdata[7:0]                  = st_reg.opcode;
                    st_next.rdata[STAT_BUSY_BIT]        = (st_reg.phase != PH_IDLE);
                    st_next.rdata[STAT_DONE_BIT]        = st_reg.flags.done;
                    st_next.rdata[STAT_ILLEGAL_BIT]     = st_reg.flags.illegal;
                    st_next.rdata[STAT_SW1_BIT]         = st_reg.flags.operand_sign_reversed;
                    st_next.rdata[STAT_MOVE_BIT]        = st_reg.flags.move_augend_request;
                    st_next.rdata[STAT_FPR_BIT]         = st_reg.flags.polarity_reversed_flag;
                    st_next.rdata[STAT_RTZ_BIT]         = st_reg.flags.result_zero_flag;
                    st_next.rdata[STAT_AUG_BIT]         = st_reg.flags.align_augend_right;
                    st_next.rdata[STAT_ADD_BIT]         = st_reg.flags.align_addend_right;
                    st_next.rdata[STAT_PHASE_LO +: 3]   = st_reg.phase;
                end
                REG_ACC_HI:  st_next.rdata[HI_W-1:0] = st_reg.acc[MANT_W-1:LO_W];
                REG_ACC_LO:  st_next.rdata           = st_reg.acc[LO_W-1:0];
                REG_OPND_HI: st_next.rdata[HI_W-1:0] = st_reg.opnd[MANT_W-1:LO_W];
                REG_OPND_LO: st_next.rdata           = st_reg.opnd[LO_W-1:0];
                REG_EXP: begin
                    st_next.rdata[7:0]                 = st_reg.exp_diff;
                    st_next.rdata[EXP_SAVED_LO +: 8]   = st_reg.saved_exp;
                end
                default:     st_next.rdata = '0;
            endcase
        end

        // Register write: only while idle, so software cannot tear operands
        if (WR && st_reg.phase == PH_IDLE) begin
            case (bus_addr)
                REG_CTRL: begin
                    st_next.opcode = WDATA[7:0];
                    if (WDATA[CTRL_START_BIT]) begin
                        st_next.flags.illegal = !((WDATA[6:0] == OP_ADD_SHORT) ||
                                                  (WDATA[6:0] == OP_SUB_SHORT) ||
                                                  (WDATA[6:0] == OP_ADD_LONG)  ||
                                                  (WDATA[6:0] == OP_SUB_LONG));
                        // A refused code is no start, so the last result stays done
                        if (!st_next.flags.illegal) begin
                            st_next.flags.done = 1'b0;
                            st_next.phase      = PH_DECIDE;
                        end
                    end
                end
                REG_ACC_HI:  st_next.acc[MANT_W-1:LO_W]  = WDATA[HI_W-1:0];
                REG_ACC_LO:  st_next.acc[LO_W-1:0]       = WDATA;
                REG_OPND_HI: st_next.opnd[MANT_W-1:LO_W] = WDATA[HI_W-1:0];
                REG_OPND_LO: st_next.opnd[LO_W-1:0]      = WDATA;
                REG_EXP: begin
                    st_next.exp_diff  = WDATA[7:0];
                    st_next.saved_exp = WDATA[EXP_SAVED_LO +: 8];
                end
                default: ;
            endcase
        end

        // Sign-reversed flag drops when the ninth phase is absent on an unrefused clock, unless the decide or align phase below sets it
        if (!NINTH_PHASE && !SHORT_TIMING_CLASS) begin
            st_next.flags.operand_sign_reversed = 1'b0;
        end

        // First phase clears the zero flag; a set below still wins.
        // Refused clocks must not reach this flag either
        if (FIRST_PHASE && !SHORT_TIMING_CLASS) begin
            st_next.flags.result_zero_flag = 1'b0;
        end

        // Refused clocks freeze every phase until service ends; only a start write from idle still moves to the decide phase
        if (!SHORT_TIMING_CLASS) begin
            case (st_reg.phase)
                PH_IDLE: ;

                // Compare exponents and preset the adder for alignment
                PH_DECIDE: begin
                    st_next.first_clk = 1'b1;
                    if (exp_zero) begin
                        // Equal exponents: straight to the add phase
                        st_next.mode  = op_add ? AD_SUM : AD_DIFF;
                        st_next.exp_diff = exp_minus_bias;
                        st_next.flags.result_zero_flag = 1'b0;
                        st_next.phase = PH_ADD;
                    end else if (exp_neg) begin
                        if (!st_reg.flags.result_zero_flag) begin
                            st_next.flags.align_augend_right = 1'b1;
                            st_next.flags.align_addend_right = 1'b0;
                            if (st_reg.acc[SIGN_BIT]) begin
                                st_next.mode = AD_NEG_ACC;
                                st_next.flags.operand_sign_reversed  = 1'b1;
                                st_next.flags.polarity_reversed_flag = 1'b1;
                            end else begin
                                st_next.mode = AD_PASS_ACC;
                            end
                            st_next.exp_diff  = st_reg.exp_diff + 8'h01;
                            st_next.saved_exp = st_reg.opnd[EXP_TOP_HI:EXP_TOP_LO];
                            st_next.phase     = PH_ALIGN;
                        end else begin
                            // Zero mantissa already known: nothing to align
                            st_next.mode  = op_add ? AD_SUM : AD_DIFF;
                            st_next.exp_diff = exp_minus_bias;
                            st_next.flags.result_zero_flag = 1'b0;
                            st_next.phase = PH_ADD;
                        end
                    end else begin
                        st_next.flags.align_addend_right = 1'b1;
                        st_next.flags.align_augend_right = 1'b0;
                        st_next.flags.move_augend_request = 1'b1;
                        if (st_reg.opnd[SIGN_BIT]) begin
                            st_next.mode = AD_NEG_OPND;
                            st_next.flags.operand_sign_reversed = 1'b1;
                        end else begin
                            st_next.mode = AD_PASS_OPND;
                        end
                        // Polarity flips when addend sign and add/subtract agree
                        st_next.flags.polarity_reversed_flag =
                            !(st_reg.opnd[SIGN_BIT] ^ op_add);
                        st_next.exp_diff = st_reg.exp_diff - 8'h01;
                        st_next.phase    = PH_ALIGN;
                    end
                end

                // One hex digit per clock until exponents meet or mantissa is gone
                PH_ALIGN: begin
                    st_next.first_clk = 1'b0;
                    if (st_reg.first_clk && st_reg.flags.move_augend_request) begin
                        st_next.opnd = st_reg.acc;
                        st_next.flags.move_augend_request = 1'b0;
                    end
                    st_next.acc = shifted;
                    // Sign-reversed is re-asserted each clock so it survives
                    if (st_reg.flags.operand_sign_reversed) begin
                        st_next.flags.operand_sign_reversed = 1'b1;
                    end
                    if (addsub_prepare) begin
                        st_next.mode = (op_add || st_reg.flags.operand_sign_reversed)
                                       ? AD_SUM : AD_DIFF;
                        st_next.exp_diff = exp_minus_bias;
                        st_next.flags.result_zero_flag = 1'b0;
                        st_next.phase = PH_ADD;
                    end else begin
                        st_next.mode = AD_PASS_ACC;
                        if (st_reg.flags.align_augend_right) begin
                            st_next.exp_diff = st_reg.exp_diff + 8'h01;
                        end else begin
                            st_next.exp_diff = st_reg.exp_diff - 8'h01;
                        end
                        if (sum_zero) begin
                            st_next.flags.result_zero_flag = 1'b1;
                        end
                    end
                end

                // Single clock: sum into operand register, accumulator cleared
                PH_ADD: begin
                    st_next.opnd  = sum_bus;
                    st_next.mode  = sum_bus[EXT_BIT] ? AD_NEG_OPND : AD_PASS_OPND;
                    st_next.acc   = '0;
                    st_next.phase = PH_POST;
                end

                // Absolute value and overflow correction
                PH_POST: begin
                    if (st_reg.opnd[EXT_BIT]) begin
                        st_next.flags.polarity_reversed_flag =
                            !st_reg.flags.polarity_reversed_flag;
                    end
                    if (st_reg.opnd[EXT_BIT] != st_reg.opnd[SIGN_BIT]) begin
                        st_next.acc      = sum_bus >> HEX_SHIFT;
                        st_next.exp_diff = st_reg.exp_diff + 8'h01;
                    end else begin
                        st_next.acc = sum_bus;
                    end
                    st_next.flags.align_augend_right = 1'b0;
                    st_next.flags.align_addend_right = 1'b0;
                    st_next.flags.done = 1'b1;
                    st_next.phase = PH_IDLE;
                end

                default: st_next.phase = PH_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= FPA_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // RDATA and DONE come straight from flip-flops; BUSY is decoded from the phase register
    assign RDATA = st_reg.rdata;
    assign BUSY  = (st_reg.phase != PH_IDLE);
    assign DONE  = st_reg.flags.done;

    // Held opcode decode, spare; start legality is judged on the write data
    logic unused_ok;
    assign unused_ok = op_legal;

endmodule : fpa_align_seq

`default_nettype wire

// >>> bench/fpa_align_seq_props.sv
// Port checks for the align sequencer
`default_nettype none
module fpa_align_props
    import fpa_pkg::*;
#(parameter int ADDR_W = 8) (
    input wire logic              CLK,
    input wire logic              RSTN,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0]       WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [31:0]       RDATA,
    input wire logic              SHORT_TIMING_CLASS,
    input wire logic              FIRST_PHASE,
    input wire logic              NINTH_PHASE,
    input wire logic              BUSY,
    input wire logic              DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    // Start decode; a frozen legal start is left unchecked, its outcome is open
    wire logic st = WR && ADDR == REG_CTRL && WDATA[CTRL_START_BIT];
    wire logic ok = WDATA[6:0] inside {OP_ADD_SHORT, OP_SUB_SHORT, OP_ADD_LONG, OP_SUB_LONG};
    wire logic go = st && ok && !BUSY && !SHORT_TIMING_CLASS;
    wire logic no = st && !ok && !BUSY;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    a_start_busy: assert property (go |=> BUSY && !DONE) else $error("start lost");
    a_bad_code: assert property (no |=> !BUSY) else $error("bad code ran");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == '0) else $error("stray rdata");
    a_min_run: assert property ($rose(BUSY) |-> BUSY[*3]) else $error("short run");
    a_run_ends: assert property ($rose(BUSY) |-> ##[3:300] !BUSY) else $error("hang");
    a_freeze_hold: assert property (SHORT_TIMING_CLASS && BUSY |=> $stable({BUSY, DONE}))
        else $error("moved while frozen");
    a_done_end: assert property ($fell(BUSY) |-> DONE) else $error("no done");
    a_done_hold: assert property (DONE && !go |=> DONE) else $error("done dropped");
    c_run_done: cover property ($fell(BUSY));
    c_frozen: cover property (SHORT_TIMING_CLASS && BUSY);
    c_bad_code: cover property (no);
endmodule : fpa_align_props
bind fpa_align_seq fpa_align_props #(.ADDR_W(ADDR_W)) i_fpa_align_props (
    .CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .SHORT_TIMING_CLASS, .FIRST_PHASE, .NINTH_PHASE, .BUSY, .DONE
);
`default_nettype wire

// >>> bench/fpa_cpu_model.sv
// Processor phase sequencer model facing the align sequencer
`default_nettype none
module fpa_cpu_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic freeze_req,
    input  wire logic busy,
    output logic      short_class,
    output logic      first_ph,
    output logic      ninth_ph
);
    timeunit 1ns;
    timeprecision 1ps;
    // I/O service window and idle first-phase pulses, both off one edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            short_class <= 1'b0;
            first_ph    <= 1'b0;
        end else begin
            short_class <= freeze_req;
            first_ph    <= !busy && !first_ph;
        end
    end
    // Ninth phase held over the run so the sign flag is not wiped mid-way
    assign ninth_ph = busy;
endmodule : fpa_cpu_model
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the align sequencer
`default_nettype none
module testbench
    import fpa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, frz = 0;
    logic [7:0]  addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        busy, done, stc, fph, nph;
    logic [6:0]  ops [4] = '{OP_ADD_SHORT, OP_SUB_SHORT, OP_ADD_LONG, OP_SUB_LONG};
    int          bad_count = 0, n_compared = 0;
    // Clock, 4 ns period
    always #2 clk = ~clk;
    fpa_align_seq i_fpa_align_seq (.CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SHORT_TIMING_CLASS(stc), .FIRST_PHASE(fph),
        .NINTH_PHASE(nph), .BUSY(busy), .DONE(done));
    fpa_cpu_model i_fpa_cpu_model (.clk(clk), .rst_n(rst_n), .freeze_req(frz),
        .busy(busy), .short_class(stc), .first_ph(fph), .ninth_ph(nph));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask : rd_reg
    task automatic ld(input logic [31:0] ah, oh, ol, input logic [7:0] e);
        wr_reg(REG_ACC_HI, ah);
        wr_reg(REG_ACC_LO, 32'h0);
        wr_reg(REG_OPND_HI, oh);
        wr_reg(REG_OPND_LO, ol);
        wr_reg(REG_EXP, {24'h0, e});
    endtask : ld
    // Start, optionally freeze for four clocks, then wait for done
    task automatic run(input logic [6:0] op, input bit hold);
        wr_reg(REG_CTRL, {23'h0, 1'b1, 1'b0, op});
        if (hold) begin
            frz <= 1'b1;
            repeat (4) @(posedge clk);
            #1;
            chk({31'h0, done}, 32'h0);
            frz <= 1'b0;
        end
        @(posedge clk);
        #1;
        for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk);
        chk({31'h0, done}, 32'h1);
        @(posedge clk);
    endtask : run
    task automatic end_sim;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // Watchdog: the tests need well under 2000 clocks
    initial begin
        #20000;
        bad_count++;
        end_sim();
    end
    // Test sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(REG_CTRL, '1, 32'h0);
        rd_reg(8'h18, '1, 32'h0);
        $display("test reset done");
        foreach (ops[k]) begin
            ld(32'h10000, 32'h20000, 32'h0, 8'h00);
            run(ops[k], k == 1);
            rd_reg(REG_ACC_HI, '1, ops[k][0] ? 32'h30000 : 32'h10000);
            if (k == 1) rd_reg(REG_CTRL, 32'h2000, 32'h2000);
        end
        $display("test opcodes done");
        // Negative then positive difference, one hex shift each way
        for (int j = 0; j < 2; j++) begin
            ld(32'h10000, 32'h10000, 32'h41000000, j ? 8'h01 : 8'hff);
            run(OP_ADD_SHORT, 0);
            rd_reg(REG_ACC_HI, '1, 32'h11000);
            if (j == 1) rd_reg(REG_ACC_LO, '1, 32'h00100000);
            if (j == 0) rd_reg(REG_EXP, 32'hffff, 32'h4101);
        end
        $display("test align done");
        ld(32'h800000, 32'h800000, 32'h0, 8'h00);
        run(OP_ADD_LONG, 0);
        rd_reg(REG_ACC_HI, '1, 32'h100000);
        wr_reg(REG_CTRL, 32'h17f);
        rd_reg(REG_CTRL, 32'h500, 32'h400);
        $display("test overflow and bad code done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
